//--- filter_cfg_pkg.sv
// Purpose: constants and carrier types for the switch input filter config block
// Assumes: 40 MHz clock, APB register access with 32-bit data
// Notes: one config word plus one status word
`default_nettype none
package filter_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] cfg_offset = 8'h00;
  localparam logic [7:0] state_offset = 8'h04;
  // field positions in the config word
  localparam int input0_wetting_diag_enable_pos = 18;
  localparam int supply_measure_enable_pos = 17;
  localparam int thermal_cut_disable_group_a_pos = 16;
  localparam int debounce_depth_hi = 15;
  localparam int debounce_depth_lo = 14;
  localparam int thermal_cut_disable_group_b_pos = 13;
  localparam logic [31:0] cfg_reset = 32'h0000_0000;
  localparam logic [31:0] cfg_write_mask = 32'h0007_E000;
  // wetting current codes
  localparam logic [2:0] wet_2ma = 3'h2;
  localparam logic [2:0] wet_10ma = 3'h4;
  localparam logic [2:0] wet_15ma = 3'h5;

  typedef struct packed {
    logic input0_wetting_diag_enable;
    logic supply_measure_enable;
    logic thermal_cut_disable_group_a;
    logic [1:0] debounce_depth;
    logic thermal_cut_disable_group_b;
  } cfg_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : filter_cfg_pkg
`default_nettype wire

//--- debounce_lane.sv
// Purpose: debounce filter for one switch input
// Assumes: sample_strobe_in pulses once per new sample
// Notes: depth 0 passes every sample straight through
`timescale 1ns/1ps
`default_nettype none
module debounce_lane (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sample_strobe_in,
  input wire logic sample_in,
  input wire logic [1:0] depth_in,
  output logic valid_out,
  output logic accept_out
);
  logic last_sample;
  logic seen;
  logic [1:0] run;
  logic [1:0] next_run;

  // run length counts equal samples beyond the first, saturating at 3
  // the reset value of last_sample is no real sample, so the first strobe starts a run
  always_comb begin
    if (!seen || sample_in != last_sample) begin
      next_run = 2'h0; // restart the run on change
    end else if (run == 2'h3) begin
      next_run = run;
    end else begin
      next_run = run + 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_sample <= 1'b0;
      seen <= 1'b0;
      run <= 2'h0;
    end else if (sample_strobe_in) begin
      last_sample <= sample_in;
      seen <= 1'b1;
      run <= next_run;
    end
  end

  // accept when depth extra equal samples seen; else hold last valid
  assign accept_out = sample_strobe_in && (next_run >= depth_in);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_out <= 1'b0;
    end else if (accept_out) begin
      valid_out <= sample_in; // only accepted samples go on
    end
  end
endmodule // debounce_lane
`default_nettype wire

//--- switch_input_filter_config.sv
// Purpose: config register slice with debounce, supply measure and thermal cut control
// Assumes: APB slave, zero wait states, inputs synchronous to clk_in
// Notes: state word at offset 4 shows filtered inputs and cut status
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - depth field bits 15-14: 0 every sample, 1..3 need 2..4 equal samples
// - only filter-accepted samples go to threshold evaluation; depth resets to zero
// - bit 17 set requests supply measurement at each polling cycle end
// - bit 16 clear: thermal warning cuts group a 10/15 mA inputs to 2 mA
// - bit 13 clear: thermal warning cuts group b 10/15 mA inputs to 2 mA
// - bit 18 enables wetting diagnostic for switch input zero; resets clear
module switch_input_filter_config #(
  parameter int num_inputs = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire filter_cfg_pkg::apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sample_strobe_in,
  input wire logic [num_inputs-1:0] raw_sample_in,
  input wire logic [num_inputs-1:0] source_input_group_in,
  input wire logic [num_inputs*3-1:0] wet_setting_in,
  input wire logic thermal_warning_event_in,
  input wire logic poll_end_in,
  output logic [num_inputs-1:0] eval_sample_out,
  output logic [num_inputs-1:0] eval_valid_out,
  output logic [num_inputs*3-1:0] wet_applied_out,
  output logic supply_measure_start_out,
  output logic input0_wetting_diag_out
);
  import filter_cfg_pkg::*;

  cfg_t cfg;
  logic [num_inputs-1:0] accept;
  logic [num_inputs-1:0] cut_active;
  logic [31:0] cfg_word;
  logic wr_en;
  logic rd_sel;

  // returns true when the address hits a mapped register
  function automatic logic is_mapped(input logic [31:0] a);
    return (a == {24'h00_0000, cfg_offset}) || (a == {24'h00_0000, state_offset});
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads zero with pslverr
  assign pready_out = 1'b1;
  assign wr_en = apb_in.psel && apb_in.penable && apb_in.pwrite
    && (apb_in.paddr == {24'h00_0000, cfg_offset});
  assign rd_sel = apb_in.psel && apb_in.penable;
  assign pslverr_out = rd_sel && !is_mapped(apb_in.paddr);

  always_comb begin
    cfg_word = cfg_reset;
    cfg_word[input0_wetting_diag_enable_pos] = cfg.input0_wetting_diag_enable;
    cfg_word[supply_measure_enable_pos] = cfg.supply_measure_enable;
    cfg_word[thermal_cut_disable_group_a_pos] = cfg.thermal_cut_disable_group_a;
    cfg_word[debounce_depth_hi:debounce_depth_lo] = cfg.debounce_depth;
    cfg_word[thermal_cut_disable_group_b_pos] = cfg.thermal_cut_disable_group_b;
  end

  // all fields clear at reset, so filter starts bypassed
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg <= '0;
    end else if (wr_en) begin
      cfg.input0_wetting_diag_enable <= apb_in.pwdata[input0_wetting_diag_enable_pos];
      cfg.supply_measure_enable <= apb_in.pwdata[supply_measure_enable_pos];
      cfg.thermal_cut_disable_group_a <= apb_in.pwdata[thermal_cut_disable_group_a_pos];
      cfg.debounce_depth <= apb_in.pwdata[debounce_depth_hi:debounce_depth_lo];
      cfg.thermal_cut_disable_group_b <= apb_in.pwdata[thermal_cut_disable_group_b_pos];
    end
  end

  // read data registered from the setup phase so it is stable in access
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_in.psel && !apb_in.penable) begin
      if (apb_in.paddr == {24'h00_0000, cfg_offset}) begin
        prdata_out <= cfg_word;
      end else if (apb_in.paddr == {24'h00_0000, state_offset}) begin
        prdata_out <= 32'({cut_active, eval_sample_out});
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one debounce lane per input
  for (genvar i = 0; i < num_inputs; i++) begin : g_lane
    debounce_lane u_lane (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .sample_strobe_in(sample_strobe_in),
      .sample_in(raw_sample_in[i]),
      .depth_in(cfg.debounce_depth),
      .valid_out(eval_sample_out[i]),
      .accept_out(accept[i])
    );
  end

  // pulse marks a freshly accepted sample for threshold evaluation
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      eval_valid_out <= '0;
    end else begin
      eval_valid_out <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // thermal cut: group b is the source group, group a the rest
  for (genvar i = 0; i < num_inputs; i++) begin : g_cut
    logic high_setting;
    logic cut_allowed;
    assign high_setting = (wet_setting_in[i*3 +: 3] == wet_10ma)
      || (wet_setting_in[i*3 +: 3] == wet_15ma);
    assign cut_allowed = source_input_group_in[i] ? !cfg.thermal_cut_disable_group_b
      : !cfg.thermal_cut_disable_group_a;
    assign cut_active[i] = thermal_warning_event_in && high_setting && cut_allowed;
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        wet_applied_out[i*3 +: 3] <= 3'h0;
      end else begin
        wet_applied_out[i*3 +: 3] <= cut_active[i] ? wet_2ma : wet_setting_in[i*3 +: 3];
      end
    end
  end

  // measurement request only at poll end while enabled
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      supply_measure_start_out <= 1'b0;
    end else begin
      supply_measure_start_out <= poll_end_in && cfg.supply_measure_enable;
    end
  end

  assign input0_wetting_diag_out = cfg.input0_wetting_diag_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // supply measurement requests
  a_measure_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    supply_measure_start_out |-> $past(poll_end_in) && $past(cfg.supply_measure_enable))
    else $error("supply measure started without enable and poll end");
  a_measure_fires: assert property (@(posedge clk_in) disable iff (!resetn_in)
    poll_end_in && cfg.supply_measure_enable |=> supply_measure_start_out)
    else $error("supply measure missed");
  a_supply_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !cfg.supply_measure_enable |=> !supply_measure_start_out)
    else $error("supply measure started while disabled");

  // config register and its read path
  a_cfg_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !wr_en |=> $stable(cfg))
    else $error("config changed without a write");
  a_state_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    apb_in.psel && apb_in.penable && apb_in.pwrite
    && apb_in.paddr != {24'h00_0000, cfg_offset} |=> $stable(cfg))
    else $error("config changed by a write elsewhere");
  a_cfg_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    apb_in.psel && !apb_in.penable && apb_in.paddr == {24'h00_0000, cfg_offset}
    |=> prdata_out[debounce_depth_hi:debounce_depth_lo] == $past(cfg.debounce_depth))
    else $error("depth field read back wrong");
  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    apb_in.psel && !apb_in.penable && !is_mapped(apb_in.paddr)
    |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read returned data");

  // thermal cut: input 0 stands for group a and input 1 for group b
  // settings below 10 mA are left alone, so only the high codes arm the cut
  a_cut_group_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    thermal_warning_event_in && !source_input_group_in[0] && !cfg.thermal_cut_disable_group_a
    && (wet_setting_in[2:0] == wet_10ma || wet_setting_in[2:0] == wet_15ma)
    |=> wet_applied_out[2:0] == wet_2ma)
    else $error("group a cut missing");
  a_keep_group_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !source_input_group_in[0] && cfg.thermal_cut_disable_group_a
    |=> wet_applied_out[2:0] == $past(wet_setting_in[2:0]))
    else $error("group a cut while disabled");
  a_cut_group_b: assert property (@(posedge clk_in) disable iff (!resetn_in)
    thermal_warning_event_in && source_input_group_in[1] && !cfg.thermal_cut_disable_group_b
    && (wet_setting_in[5:3] == wet_10ma || wet_setting_in[5:3] == wet_15ma)
    |=> wet_applied_out[5:3] == wet_2ma)
    else $error("group b cut missing");
  a_keep_group_b: assert property (@(posedge clk_in) disable iff (!resetn_in)
    source_input_group_in[1] && cfg.thermal_cut_disable_group_b
    |=> wet_applied_out[5:3] == $past(wet_setting_in[5:3]))
    else $error("group b cut while disabled");
  a_cut_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    resetn_in && !thermal_warning_event_in
    |=> wet_applied_out == $past(wet_setting_in))
    else $error("wetting code changed without a warning");

  // debounce filter, watched on lane 0 (all lanes in a_eval_only), and the diagnostic enable write
  a_bypass_pass: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sample_strobe_in && cfg.debounce_depth == 2'h0
    |=> eval_sample_out[0] == $past(raw_sample_in[0]))
    else $error("bypass filter did not pass sample");
  a_depth_full: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sample_strobe_in && cfg.debounce_depth == 2'h3 && g_lane[0].u_lane.run == 2'h1
    && raw_sample_in[0] == g_lane[0].u_lane.last_sample |=> !eval_valid_out[0])
    else $error("depth three accepted a third sample");
  a_accept_passes: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept[0] |=> eval_valid_out[0] && eval_sample_out[0] == $past(raw_sample_in[0]))
    else $error("accepted sample not passed on");
  a_depth_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sample_strobe_in && raw_sample_in[0] != g_lane[0].u_lane.last_sample
    && cfg.debounce_depth != 2'h0 |=> $stable(eval_sample_out[0]))
    else $error("changed sample accepted too early");
  a_diag_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_en |=> input0_wetting_diag_out == $past(apb_in.pwdata[input0_wetting_diag_enable_pos]))
    else $error("diagnostic enable not written");
  a_eval_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !$past(sample_strobe_in) |-> $stable(eval_sample_out) && eval_valid_out == '0)
    else $error("evaluation changed without accepted sample");
endmodule // switch_input_filter_config
`default_nettype wire

//--- host_apb_model.sv
// Purpose: host side model that issues APB reads and writes to the config block
// Assumes: slave pready and pslverr sampled at the rising edge of clk_in
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module host_apb_model (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output var filter_cfg_pkg::apb_req_t apb_out,
  output var logic hung_out
);
  import filter_cfg_pkg::*;
  initial begin
    apb_out = '0;
    hung_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one transfer: setup, then access held until pready is seen high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    apb_out.psel <= 1'b1;
    apb_out.pwrite <= wr;
    apb_out.paddr <= a;
    apb_out.pwdata <= d;
    apb_out.penable <= 1'b0;
    @(posedge clk_in);
    apb_out.penable <= 1'b1;
    // bounded wait so a dead slave cannot hang the run
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 50);
    hung_out = (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    apb_out.psel <= 1'b0;
    apb_out.penable <= 1'b0;
    apb_out.paddr <= ~a;
    apb_out.pwdata <= ~d;
  endtask
endmodule // host_apb_model
`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench for the switch input filter config block
// Assumes: 40 MHz clock, four inputs, inputs 1 and 3 in the source group
// Notes: every scenario is its own task and judges its own results
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import filter_cfg_pkg::*;
  logic clk_in, resetn_in, pready, pslverr, strobe, therm, poll, sup, diag, hung;
  logic [31:0] prdata, rd;
  logic [3:0] raw, grp, eval_s, eval_v;
  logic [11:0] wet, wet_out;
  logic err;
  apb_req_t apb;
  int bad_count = 0;
  int checks_done = 0;
  switch_input_filter_config #(.num_inputs(4)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .apb_in(apb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .sample_strobe_in(strobe), .raw_sample_in(raw), .source_input_group_in(grp),
    .wet_setting_in(wet), .thermal_warning_event_in(therm), .poll_end_in(poll),
    .eval_sample_out(eval_s), .eval_valid_out(eval_v), .wet_applied_out(wet_out),
    .supply_measure_start_out(sup), .input0_wetting_diag_out(diag));
  host_apb_model i_host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .apb_out(apb), .hung_out(hung));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bus access; a dead slave ends the run at once
  task automatic apb_rw(input logic wr, input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(wr, a, d, rd, err);
    if (hung) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    apb_rw(1'b0, 32'(cfg_offset), 32'h0000_0000);
    check("cfg reset", rd, cfg_reset);
    check("diag reset", 32'(diag), 32'h0000_0000);
    apb_rw(1'b1, 32'(cfg_offset), 32'hFFFF_FFFF);
    apb_rw(1'b0, 32'(cfg_offset), 32'h0000_0000);
    check("cfg readback", rd, cfg_write_mask);
    check("diag set", 32'(diag), 32'h0000_0001);
    apb_rw(1'b1, 32'(state_offset), 32'h0000_0000);
    apb_rw(1'b0, 32'(cfg_offset), 32'h0000_0000);
    check("state write ignored", rd, cfg_write_mask);
    apb_rw(1'b0, 32'h0000_0010, 32'h0000_0000);
    check("unmapped err", 32'(err), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    $display("test_regs done");
  endtask
  // one sample strobe; acc says whether the filter should accept it
  task automatic sample(input logic [3:0] v, input logic acc, input logic [3:0] held);
    @(posedge clk_in);
    strobe <= 1'b1;
    raw <= v;
    @(posedge clk_in);
    strobe <= 1'b0;
    #1;
    check("eval valid", 32'(eval_v), acc ? 32'h0000_000F : 32'h0000_0000);
    check("eval sample", 32'(eval_s), acc ? 32'(v) : 32'(held));
  endtask
  task automatic test_filter();
    logic [3:0] t;
    for (int d = 0; d < 4; d++) begin
      t = d[0] ? 4'h0 : 4'hF;
      apb_rw(1'b1, 32'(cfg_offset), 32'(d) << debounce_depth_lo);
      for (int i = 0; i < d; i++) sample(t, 1'b0, ~t);
      if (d > 0) sample(~t, 1'b0, ~t);
      for (int i = 0; i < d; i++) sample(t, 1'b0, ~t);
      sample(t, 1'b1, ~t);
    end
    $display("test_filter done");
  endtask
  task automatic test_supply();
    for (int e = 0; e < 2; e++) begin
      apb_rw(1'b1, 32'(cfg_offset), 32'(e) << supply_measure_enable_pos);
      @(posedge clk_in);
      poll <= 1'b1;
      @(posedge clk_in);
      poll <= 1'b0;
      #1;
      check("supply start", 32'(sup), 32'(e));
      @(posedge clk_in);
      #1;
      check("supply idle", 32'(sup), 32'h0000_0000);
    end
    $display("test_supply done");
  endtask
  // group b is inputs 1 and 3; all inputs run at 10 or 15 mA
  task automatic test_thermal();
    logic [31:0] cfgs [3] = '{32'h0000_0000, 32'h0001_0000, 32'h0000_2000};
    logic [11:0] exps [3] = '{12'h492, 12'h514, 12'hAAA};
    @(posedge clk_in);
    therm <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      apb_rw(1'b1, 32'(cfg_offset), cfgs[k]);
      repeat (2) @(posedge clk_in);
      #1;
      check("wet applied", 32'(wet_out), 32'(exps[k]));
    end
    // group a inputs 0 and 2 are cut, last filtered samples were all low
    apb_rw(1'b0, 32'(state_offset), 32'h0000_0000);
    check("state word", rd, 32'h0000_0050);
    @(posedge clk_in);
    therm <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("wet no warning", 32'(wet_out), 32'(wet));
    $display("test_thermal done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    strobe = 1'b0;
    raw = 4'h0;
    grp = 4'hA;
    wet = {3'h5, 3'h4, 3'h5, 3'h4};
    therm = 1'b0;
    poll = 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    test_regs();
    test_filter();
    test_supply();
    test_thermal();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
